// [dv/pack_status_reporting_test.sv]
// pack_status_reporting_test: self-checking bench for psr_status.
// assumes: psr_host on the bus, shortened pin hold and blow_pin_state periods.
`timescale 1ns/10ps
module pack_status_reporting_test
  import psr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, sv, irq, rok, wok, cok;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, dq, rd, r;
  logic [15:0] sc;
  logic dsl, slp, ldt, ldm, ldp, pin, pfl, ss, fp, nm, cu, pwe, pco, prq, pdn;
  logic [1:0] sec;
  logic shut, pend, blk, fs;
  logic [2:0] acc;
  int sv_seen = 0;
  logic [31:0] seed = 32'hAB46DFAA;
  int errors = 0;
  int comparisons = 0;

  always #5 clk_i = ~clk_i;

  psr_status #(.PIN_HOLD_CYC(20), .BLOW_PIN_STATE_PERIOD_CYC(16)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dq), .wb_ack_o(ack),
    .deep_sleep_i(dsl), .sleep_i(slp), .ld_timed_out_i(ldt), .ld_measure_done_i(ldm),
    .ld_pullup_on_i(ldp), .rst_shut_pin_i(pin), .pf_any_i(pfl), .safety_any_i(ss),
    .blow_pin_state_pin_i(fp), .normal_mode_i(nm), .security_i(sec), .cfg_update_i(cu),
    .prog_write_en_i(pwe), .prog_cond_ok_i(pco), .prog_req_i(prq), .prog_done_i(pdn),
    .cfg_read_ok_o(rok), .cfg_write_ok_o(wok), .all_cmds_ok_o(cok), .subcmd_o(sc),
    .subcmd_valid_o(sv), .irq_o(irq));
  psr_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(dq), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  ////////////////////////////////////////
  // helpers: random source, model of the battery word, checks
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] eb();
    return {16'h0, slp, 1'b0, shut, pfl, ss, fs, sec, blk, pend, 6'h00};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, rd);
    chk($sformatf("read %h", a), rd, e);
  endtask
  task automatic rb();
    rdc(PSR_ADR_BATT_STATUS, eb());
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // counts completed subcommands as the design announces them
  always @(posedge clk_i) begin
    if (sv === 1'b1) sv_seen++;
  end
  // main sequence; model flags follow each stimulus step
  initial begin
    {dsl, slp, ldt, ldm, ldp, pin, pfl, ss, fp, cu, prq, pdn} = 12'h000;
    {nm, pwe, pco, sec} = 5'h1D;
    {shut, pend, blk, fs} = 4'h0;
    step(12);
    rst_i <= 1'b0;
    u_host.xfer(1'b1, PSR_ADR_CTRL_STATUS, {16'h0, PSR_SUBCMD_SHUTDOWN}, rd);
    shut = 1'b1;
    rdc(PSR_ADR_CTRL_STATUS, {16'h0, PSR_CTRL_TOKEN});
    rdc(PSR_ADR_CTRL_STATUS, 32'h0);
    rdc(PSR_ADR_SUBCMD_LAST, {16'h0, PSR_SUBCMD_SHUTDOWN});
    rb();
    u_host.xfer(1'b1, PSR_ADR_SUBCMD_LO, 32'h34, rd);
    u_host.xfer(1'b1, PSR_ADR_SUBCMD_HI, 32'h12, rd);
    rdc(PSR_ADR_SUBCMD_LAST, 32'h1234);
    chk("subcmd_o", {16'h0, sc}, 32'h1234);
    chk("subcmd pulses", sv_seen, 32'h2);
    // random levels; security walks all four codes
    for (int i = 0; i < 8; i++) begin
      r = xs();
      {dsl, slp, ldt, ldp, pfl, ss, fp, pco, pwe} <= r[8:0];
      sec <= i[1:0];
      ldm <= 1'b1;
      step(1);
      ldm <= 1'b0;
      ldp <= r[9];
      fs = r[2];
      blk = ~(r[1] & r[0]);
      acc = (i % 4 == 1) ? 3'h7 : (i % 4 == 2) ? 3'h5 : 3'h0;
      step(40);
      rdc(PSR_ADR_CTRL_STATUS, {29'h0, dsl, ldt, r[5]});
      rb();
      chk("access", {29'h0, rok, wok, cok}, {29'h0, acc});
    end
    // blow_pin_state sample holds outside normal mode and refreshes on return
    nm <= 1'b0;
    fp <= ~fs;
    step(40);
    rb();
    nm <= 1'b1;
    fs = ~fs;
    step(40);
    rb();
    u_host.xfer(1'b1, PSR_ADR_BATT_STATUS, 32'hFFFFFFFF, rd);
    rb();
    rdc(10'h3F0, 32'h0);
    // interrupt: masked, unmasked, cleared by read
    pfl <= 1'b0;
    step(3);
    u_host.xfer(1'b0, PSR_ADR_IRQ_STATUS, 32'h0, rd);
    u_host.xfer(1'b1, PSR_ADR_IRQ_MASK, 32'h0, rd);
    pfl <= 1'b1;
    step(4);
    chk("irq", {31'h0, irq}, 32'h0);
    u_host.xfer(1'b1, PSR_ADR_IRQ_MASK, 32'h02, rd);
    step(3);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(PSR_ADR_IRQ_STATUS, 32'h02);
    step(3);
    chk("irq", {31'h0, irq}, 32'h0);
    // update mode freezes blocked flag and never marks writes pending
    {pwe, pco, cu} <= 3'h3;
    sec <= PSR_SEC_OPEN;
    step(3);
    chk("access", {29'h0, rok, wok, cok}, 32'h7);
    {pco, prq} <= 2'h1;
    step(1);
    prq <= 1'b0;
    blk = 1'b0;
    step(4);
    rb();
    {cu, prq} <= 2'h1;
    step(1);
    prq <= 1'b0;
    {blk, pend} = 2'h3;
    step(4);
    rb();
    chk("access", {29'h0, rok, wok, cok}, 32'h5);
    pdn <= 1'b1;
    step(1);
    pdn <= 1'b0;
    pend = 1'b0;
    step(4);
    rb();
    // second reset, then pin held short and long
    rst_i <= 1'b1;
    step(3);
    rst_i <= 1'b0;
    shut = 1'b0;
    step(20);
    pin <= 1'b1;
    step(10);
    pin <= 1'b0;
    step(4);
    rb();
    pin <= 1'b1;
    step(30);
    pin <= 1'b0;
    shut = 1'b1;
    step(4);
    rb();
    end_sim();
  end
  // watchdog against a hung handshake
  initial begin
    step(20000);
    errors++;
    end_sim();
  end
endmodule // pack_status_reporting_test

// [dv/psr_host.sv]
// psr_host: classic Wishbone host issuing single status reads and writes.
// assumes: the bench timeout ends any wait; signals move after rising edges.
`timescale 1ns/10ps
module psr_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // idle bus from time zero
  initial begin
    {cyc_o, stb_o, we_o} = 3'h0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  ////////////////////////////////////////
  // one cycle; released address and data lines go inverted so stale values never look driven
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule // psr_host

// [dv/psr_status_props.sv]
// psr_status_props: bus and field assertions on the psr_status ports.
// assumes: one clock, synchronous active-high reset; bound below.
`timescale 1ns/10ps
module psr_status_chk
  import psr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] security_i,
  input wire logic cfg_update_i,
  input wire logic cfg_read_ok_o,
  input wire logic cfg_write_ok_o,
  input wire logic all_cmds_ok_o,
  input wire logic [15:0] subcmd_o,
  input wire logic subcmd_valid_o
);
  logic tk;
  // a request counts only while no ack stands, else a held strobe doubles it
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  AST_ACK_NEXT: assert property (tk |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  AST_CTRL_RSVD: assert property (tk && !wb_we_i && wb_adr_i == PSR_ADR_CTRL_STATUS |=>
    wb_dat_o[31:16] == 16'h0 && (wb_dat_o[15:0] == PSR_CTRL_TOKEN || wb_dat_o[15:3] == 13'h0))
    else $error("control reserved bits set");
  AST_BATT_RSVD: assert property (tk && !wb_we_i && wb_adr_i == PSR_ADR_BATT_STATUS |=>
    wb_dat_o[31:16] == 16'h0 && !wb_dat_o[14] && wb_dat_o[5:0] == 6'h0)
    else $error("battery reserved bits set");
  AST_SUBCMD: assert property (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == PSR_ADR_SUBCMD_HI
    |-> ##2 subcmd_valid_o && subcmd_o[15:8] == $past(wb_dat_i[7:0], 2)) else $error("subcmd");
  AST_VALID_PULSE: assert property ($rose(subcmd_valid_o) |=> $fell(subcmd_valid_o))
    else $error("subcmd pulse too long");
  AST_LOCKED: assert property (security_i == PSR_SEC_LOCKED |=>
    !cfg_read_ok_o && !cfg_write_ok_o && !all_cmds_ok_o) else $error("locked access");
  AST_OPEN: assert property (security_i == PSR_SEC_OPEN |=>
    cfg_read_ok_o && cfg_write_ok_o == $past(cfg_update_i)) else $error("open access");
  AST_FULL: assert property (security_i == PSR_SEC_UNRESTRICTED |=>
    cfg_read_ok_o && cfg_write_ok_o && all_cmds_ok_o) else $error("full access");
endmodule // psr_status_chk

bind psr_status psr_status_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .security_i(security_i),
  .cfg_update_i(cfg_update_i), .cfg_read_ok_o(cfg_read_ok_o),
  .cfg_write_ok_o(cfg_write_ok_o), .all_cmds_ok_o(all_cmds_ok_o),
  .subcmd_o(subcmd_o), .subcmd_valid_o(subcmd_valid_o)
);

// [verilog/psr_pkg.sv]
// psr_pkg: register map, field positions, reset values and carrier types
// for the pack status reporting block; shared by design and bench.
package psr_pkg;

  // register byte addresses (control status word 0x00, battery status 0x12 -> index*4)
  localparam logic [7:0] PSR_IDX_CTRL_STATUS = 8'h00;
  localparam logic [7:0] PSR_IDX_BATT_STATUS = 8'h12;
  localparam logic [7:0] PSR_IDX_SUBCMD_LO = 8'h3E;
  localparam logic [7:0] PSR_IDX_SUBCMD_HI = 8'h3F;
  localparam logic [7:0] PSR_IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] PSR_IDX_IRQ_MASK = 8'h41;
  localparam logic [7:0] PSR_IDX_SUBCMD_LAST = 8'h42;
  localparam logic [9:0] PSR_ADR_CTRL_STATUS = {PSR_IDX_CTRL_STATUS, 2'b00};
  localparam logic [9:0] PSR_ADR_BATT_STATUS = {PSR_IDX_BATT_STATUS, 2'b00};
  localparam logic [9:0] PSR_ADR_SUBCMD_LO = {PSR_IDX_SUBCMD_LO, 2'b00};
  localparam logic [9:0] PSR_ADR_SUBCMD_HI = {PSR_IDX_SUBCMD_HI, 2'b00};
  localparam logic [9:0] PSR_ADR_IRQ_STATUS = {PSR_IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] PSR_ADR_IRQ_MASK = {PSR_IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] PSR_ADR_SUBCMD_LAST = {PSR_IDX_SUBCMD_LAST, 2'b00};

  // fixed token returned once after a control status write
  localparam logic [15:0] PSR_CTRL_TOKEN = 16'hFFA5;
  // subcommand code that requests shutdown (arbitrary choice)
  localparam logic [15:0] PSR_SUBCMD_SHUTDOWN = 16'h0010;

  // timing
  localparam int PSR_CLK_HZ = 100_000_000;
  localparam int PSR_PIN_HOLD_MS = 1000;
  localparam int PSR_BLOW_PIN_STATE_PERIOD_MS = 1000;
  localparam int PSR_PIN_HOLD_CYC = PSR_CLK_HZ / 1000 * PSR_PIN_HOLD_MS;
  localparam int PSR_BLOW_PIN_STATE_PERIOD_CYC = PSR_CLK_HZ / 1000 * PSR_BLOW_PIN_STATE_PERIOD_MS;

  // reset values
  localparam logic [15:0] PSR_RST_WORD = 16'h0000;
  localparam logic [7:0] PSR_RST_IRQ = 8'h00;
  localparam logic [1:0] PSR_SEC_INIT = 2'h0;

  // security state encoding of bits 9:8
  typedef enum logic [1:0] {
    PSR_SEC_NOT_INIT = 2'h0,
    PSR_SEC_UNRESTRICTED = 2'h1,
    PSR_SEC_OPEN = 2'h2,
    PSR_SEC_LOCKED = 2'h3
  } psr_sec_type;

  // control status word layout
  typedef struct packed {
    logic [12:0] reserved;
    logic deepest_low_power_flag;
    logic load_detect_expired;
    logic load_pullup_was_on;
  } psr_ctrl_word_type;

  // battery status word layout (bits 5:0 are not owned by this block)
  typedef struct packed {
    logic sleep_flag;
    logic reserved;
    logic shutdown_pending;
    logic permanent_fault_flag;
    logic safety_fault_flag;
    logic blow_pin_state;
    logic security_state_hi;
    logic security_state_lo;
    logic prog_blocked;
    logic prog_pending;
    logic [5:0] other;
  } psr_batt_word_type;

  // access permissions derived from security state
  typedef struct packed {
    logic cfg_read_ok;
    logic cfg_write_ok;
    logic all_cmds_ok;
  } psr_access_type;

  // interrupt event bit positions
  localparam int PSR_EV_SHUTDOWN = 0;
  localparam int PSR_EV_PFAULT = 1;
  localparam int PSR_EV_SAFETY = 2;
  localparam int PSR_EV_BLOW_PIN_STATE = 3;
  localparam int PSR_EV_LDTO = 4;
  localparam int PSR_EV_SUBCMD = 5;

endpackage

// [verilog/psr_status.sv]
// psr_status: control and battery status words behind a classic Wishbone slave.
// assumes: one 100 MHz clock, synchronous active-high reset; fault producers
// and mode trackers live elsewhere and drive the *_i levels.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module psr_status
  import psr_pkg::*;
#(
  parameter int PIN_HOLD_CYC = PSR_PIN_HOLD_CYC,
  parameter int BLOW_PIN_STATE_PERIOD_CYC = PSR_BLOW_PIN_STATE_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic deep_sleep_i,
  input wire logic sleep_i,
  input wire logic ld_timed_out_i,
  input wire logic ld_measure_done_i,
  input wire logic ld_pullup_on_i,
  input wire logic rst_shut_pin_i,
  input wire logic pf_any_i,
  input wire logic safety_any_i,
  input wire logic blow_pin_state_pin_i,
  input wire logic normal_mode_i,
  input wire logic [1:0] security_i,
  input wire logic cfg_update_i,
  input wire logic prog_write_en_i,
  input wire logic prog_cond_ok_i,
  input wire logic prog_req_i,
  input wire logic prog_done_i,
  output logic cfg_read_ok_o,
  output logic cfg_write_ok_o,
  output logic all_cmds_ok_o,
  output logic [15:0] subcmd_o,
  output logic subcmd_valid_o,
  output logic irq_o
);

  localparam int HOLD_W = $clog2(PIN_HOLD_CYC + 1);
  localparam int BLOW_PIN_STATE_W = $clog2(BLOW_PIN_STATE_PERIOD_CYC + 1);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the first stage feeds only the second
  // both pins are asynchronous; their levels reach the logic two cycles late,
  // which is negligible against the one-second hold and sample periods
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= {blow_pin_state_pin_i, rst_shut_pin_i};
      pin_sync <= pin_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  // a request is taken only while no ack stands, so a strobe held into the
  // ack cycle is not seen twice; the master must drop it after the ack
  logic bus_req;
  logic wr_req;
  logic rd_req;
  logic wr_lo;
  logic wr_hi;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = bus_req && wb_we_i;
  assign rd_req = bus_req && !wb_we_i;
  // control status write treated as subcommand pair write
  assign wr_lo = wr_req && wb_sel_i[0] &&
    (wb_adr_i == PSR_ADR_CTRL_STATUS || wb_adr_i == PSR_ADR_SUBCMD_LO);
  assign wr_hi = wr_req &&
    ((wb_adr_i == PSR_ADR_CTRL_STATUS && wb_sel_i[1]) ||
     (wb_adr_i == PSR_ADR_SUBCMD_HI && wb_sel_i[0]));

  //////////////////////////////////////////////////////////////////////////////
  // subcommand capture: high byte completes the subcommand
  // the control status location carries both bytes in one word, the pair
  // locations one byte each on lane 0; either way the high byte fires it
  logic [15:0] subcmd;
  logic subcmd_fire;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      subcmd <= PSR_RST_WORD;
      subcmd_fire <= 1'b0;
    end else begin
      subcmd_fire <= wr_hi;
      if (wr_lo) begin
        subcmd[7:0] <= wb_dat_i[7:0];
      end
      if (wr_hi) begin
        subcmd[15:8] <= (wb_adr_i == PSR_ADR_CTRL_STATUS) ? wb_dat_i[15:8] : wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      subcmd_o <= PSR_RST_WORD;
      subcmd_valid_o <= 1'b0;
    end else begin
      subcmd_o <= subcmd;
      subcmd_valid_o <= subcmd_fire;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-shot token after a control status write
  // armed by any write there, whatever the lanes; only a read of the same
  // location spends it, so reads of other registers leave it waiting
  logic token_armed;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      token_armed <= 1'b0;
    end else if (wr_req && wb_adr_i == PSR_ADR_CTRL_STATUS) begin
      token_armed <= 1'b1;
    end else if (rd_req && wb_adr_i == PSR_ADR_CTRL_STATUS) begin
      token_armed <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // load detect pullup history, updated at each measurement
  logic ld_pullup_hist;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ld_pullup_hist <= 1'b0;
    end else if (ld_measure_done_i) begin
      ld_pullup_hist <= ld_pullup_on_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shutdown pending: subcommand or pin held longer than the hold time
  // the counter saturates at the hold time and restarts whenever the pin
  // drops, so a bouncing pin must stay asserted for the full span again
  logic [HOLD_W-1:0] hold_cnt;
  logic shut_pend;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt <= '0;
    end else if (!pin_sync[0]) begin
      hold_cnt <= '0;
    end else if (hold_cnt != HOLD_W'(PIN_HOLD_CYC)) begin
      hold_cnt <= hold_cnt + HOLD_W'(1);
    end
  end

  // stays pending until reset; the shutdown itself is handled elsewhere
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shut_pend <= 1'b0;
    end else if (subcmd_fire && subcmd == PSR_SUBCMD_SHUTDOWN) begin
      shut_pend <= 1'b1;
    end else if (hold_cnt == HOLD_W'(PIN_HOLD_CYC)) begin
      shut_pend <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // blow_pin_state pin sample once per period in normal mode
  // leaving normal mode freezes the last sample; on return the first fresh
  // sample comes one full period later, never at once
  logic [BLOW_PIN_STATE_W-1:0] blow_pin_state_cnt;
  logic blow_pin_state_smp;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blow_pin_state_cnt <= '0;
      blow_pin_state_smp <= 1'b0;
    end else if (!normal_mode_i) begin
      blow_pin_state_cnt <= '0;
    end else if (blow_pin_state_cnt == BLOW_PIN_STATE_W'(BLOW_PIN_STATE_PERIOD_CYC - 1)) begin
      blow_pin_state_cnt <= '0;
      blow_pin_state_smp <= pin_sync[1];
    end else begin
      blow_pin_state_cnt <= blow_pin_state_cnt + BLOW_PIN_STATE_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // programming blocked: live outside update mode, latched at update entry
  // resets to blocked so that nothing programs before the first check; the
  // entry check looks only at the conditions, the write enable does not apply
  logic cfg_upd_q;
  logic prog_blk;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_upd_q <= 1'b0;
      prog_blk <= 1'b1;
    end else begin
      cfg_upd_q <= cfg_update_i;
      if (cfg_update_i && !cfg_upd_q) begin
        prog_blk <= !prog_cond_ok_i;
      end else if (!cfg_update_i) begin
        prog_blk <= !prog_write_en_i || !prog_cond_ok_i;
      end
    end
  end

  // programming pending: only requests outside update mode count
  logic prog_pend;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_pend <= 1'b0;
    end else if (prog_req_i && !cfg_update_i) begin
      prog_pend <= 1'b1;
    end else if (prog_done_i) begin
      prog_pend <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status words assembled from state; reserved fields forced zero
  // the word is rebuilt every cycle; bits 5:0 of the battery word belong to
  // other logic and stay zero here
  psr_ctrl_word_type ctrl_word;
  psr_batt_word_type batt_word;

  always_comb begin
    ctrl_word = '0;
    ctrl_word.deepest_low_power_flag = deep_sleep_i;
    ctrl_word.load_detect_expired = ld_timed_out_i;
    ctrl_word.load_pullup_was_on = ld_pullup_hist;
    batt_word = '0;
    batt_word.sleep_flag = sleep_i;
    batt_word.shutdown_pending = shut_pend;
    batt_word.permanent_fault_flag = pf_any_i;
    batt_word.safety_fault_flag = safety_any_i;
    batt_word.blow_pin_state = blow_pin_state_smp;
    {batt_word.security_state_hi, batt_word.security_state_lo} = security_i;
    batt_word.prog_blocked = prog_blk;
    batt_word.prog_pending = prog_pend;
  end

  //////////////////////////////////////////////////////////////////////////////
  // access permissions from security state
  // a device that has not initialised yet grants nothing, the safe choice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_read_ok_o <= 1'b0;
      cfg_write_ok_o <= 1'b0;
      all_cmds_ok_o <= 1'b0;
    end else begin
      case (psr_sec_type'(security_i))
        PSR_SEC_UNRESTRICTED: begin
          cfg_read_ok_o <= 1'b1;
          cfg_write_ok_o <= 1'b1;
          all_cmds_ok_o <= 1'b1;
        end
        PSR_SEC_OPEN: begin
          cfg_read_ok_o <= 1'b1;
          cfg_write_ok_o <= cfg_update_i;
          all_cmds_ok_o <= 1'b1;
        end
        PSR_SEC_LOCKED: begin
          cfg_read_ok_o <= 1'b0;
          cfg_write_ok_o <= 1'b0;
          all_cmds_ok_o <= 1'b0;
        end
        default: begin
          cfg_read_ok_o <= 1'b0;
          cfg_write_ok_o <= 1'b0;
          all_cmds_ok_o <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: rising edges of flags set sticky bits; status read clears
  logic [7:0] ev_now;
  logic [7:0] ev_prev;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic stat_rd;

  assign ev_now = {2'b00, subcmd_fire, ld_timed_out_i, blow_pin_state_smp, safety_any_i,
                   pf_any_i, shut_pend};
  assign stat_rd = rd_req && wb_adr_i == PSR_ADR_IRQ_STATUS;

  // a new event in the clearing cycle survives the clear; during reset the
  // edge detector follows the flags, so a level already high at release is
  // not mistaken for a fresh event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev <= ev_now;
      irq_stat <= PSR_RST_IRQ;
    end else begin
      ev_prev <= ev_now;
      irq_stat <= (stat_rd ? PSR_RST_IRQ : irq_stat) | (ev_now & ~ev_prev);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= PSR_RST_IRQ;
    end else if (wr_req && wb_adr_i == PSR_ADR_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone answer: one wait state, ack for one cycle; unmapped reads zero
  // read data is zero outside the ack cycle, so a stale word never looks valid;
  // unmapped writes are acknowledged and dropped, there is no error reply
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    case (wb_adr_i)
      PSR_ADR_CTRL_STATUS: next_rdata[15:0] = token_armed ? PSR_CTRL_TOKEN : ctrl_word;
      PSR_ADR_BATT_STATUS: next_rdata[15:0] = batt_word;
      PSR_ADR_IRQ_STATUS: next_rdata[7:0] = irq_stat;
      PSR_ADR_IRQ_MASK: next_rdata[7:0] = irq_mask;
      PSR_ADR_SUBCMD_LAST: next_rdata[15:0] = subcmd;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_req ? next_rdata : '0;
    end
  end

endmodule // psr_status
